// >>> hw/fpl_top.sv
// front panel logic: display multiplexer, segment memory, keypad scanner
// assumes processor control lines and keypad columns synchronous to CLK
// Behaviour
// - a segment lights only while its digit and segment drivers are on
// - display is always in exactly one mode: self-scan, memory update or key read
// - in self-scan the scan clock advances the digit counter
// - counter decoded one-hot 4-to-16, segment memory drives segments
// - digit and segment drives blank for adjustable time after each scan
// - gate light lit from start to end of every measurement gate
// - with key read select low, scan/update select low enters update mode, stops multiplexing
// - in update mode only the step clock advances the digit counter
// - clear/load high with step clock clears the digit counter
// - while key read select low, all row outputs are held low
// - column detector high when any column is low, else low
// - debounced detector raises the key interrupt to the adapter
// - key read select high enables key data onto processor path
// - clear/load high with step clock loads 0111 into row shifter
// - the single zero shifts through all four row positions
// - keypad is 4 rows by 7 columns, columns pulled high idle
`timescale 1ns/10ps
module fpl_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	output logic IRQ,
	input wire logic KEY_READ_SELECT,
	input wire logic CPU_STEP_CLOCK,
	input wire logic SCAN_UPDATE_SELECT,
	input wire logic CLEAR_LOAD_SELECT,
	input wire logic [7:0] CPU_SEG_DATA,
	input wire logic CPU_SEG_WRITE,
	input wire logic GATE_ACTIVE,
	input wire logic [6:0] KEY_COLUMN_N,
	output logic [15:0] DIGIT_DRIVE,
	output logic [7:0] SEGMENT_DRIVE,
	output logic GATE_LED,
	output logic [3:0] KEY_ROW,
	output logic [10:0] KEY_DATA,
	output logic KEY_DATA_EN,
	output logic KEY_INT
);
	// segment memory, one byte per digit position
	logic [7:0] seg_mem [0:15];
	logic [3:0] digit_counter_ff;
	logic [3:0] key_row_shifter_ff;
	logic step_d_ff;
	logic [15:0] scan_cnt_ff;
	logic [15:0] blank_cnt_ff;
	logic [15:0] deb_cnt_ff;
	logic key_hold_ff;

	// software settings
	logic [15:0] scan_div_ff;
	logic [15:0] blank_ff;
	logic [15:0] debounce_ff;

	// interrupt status and mask
	logic [1:0] irq_st_ff;
	logic [1:0] irq_mask_ff;
	logic gate_d_ff;
	fpl_pkg::fpl_mode_t mode_ff;
	fpl_pkg::fpl_mode_t nxt_mode;

	// one-hot digit decode, one term per digit line
	logic [15:0] digit_decoder;
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_dec
			assign digit_decoder[g] = (digit_counter_ff == 4'(g));
		end
	endgenerate

	wire step_rise = CPU_STEP_CLOCK & ~step_d_ff;

	// scan clock tick and blanking window
	wire scan_tick = (scan_cnt_ff >= scan_div_ff);
	wire blanking = (blank_cnt_ff != 16'h0000);
	wire column_detector = ~(&KEY_COLUMN_N);
	wire deb_done = (deb_cnt_ff >= debounce_ff);
	wire key_evt = column_detector & deb_done & ~key_hold_ff &
		~KEY_READ_SELECT;
	wire gate_evt = GATE_ACTIVE & ~gate_d_ff;

	// register bus decode
	wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
	wire sel_ctrl = (WB_ADR_I == fpl_pkg::ADR_CTRL);
	wire sel_stat = (WB_ADR_I == fpl_pkg::ADR_STAT);
	wire sel_ist = (WB_ADR_I == fpl_pkg::ADR_IRQ_ST);
	wire sel_imask = (WB_ADR_I == fpl_pkg::ADR_IRQ_MASK);
	wire sel_div = (WB_ADR_I == fpl_pkg::ADR_SCAN_DIV);
	wire sel_blank = (WB_ADR_I == fpl_pkg::ADR_BLANK);
	wire sel_deb = (WB_ADR_I == fpl_pkg::ADR_DEBOUNCE);
	wire sel_seg = (WB_ADR_I[7:6] == fpl_pkg::ADR_SEG_BASE[7:6]);
	wire [3:0] seg_idx = WB_ADR_I[5:2];

	// 16-bit settings need both low byte lanes
	wire full_wr = wb_req & WB_WE_I & (WB_SEL_I[1:0] == 2'h3);

	// write-one clear of status bits
	wire [1:0] irq_clr = (wb_wr & sel_ist) ? WB_DAT_I[1:0] : 2'h0;

	// interrupt sources, one status bit each
	logic [1:0] irq_set;
	assign irq_set[fpl_pkg::IRQ_KEY] = key_evt;
	assign irq_set[fpl_pkg::IRQ_GATE] = gate_evt;
	wire [1:0] irq_next = (irq_st_ff & ~irq_clr) | irq_set;

	logic [31:0] rd_data;

	// one mode always; update when select low; key read overrides
	always_comb begin
		if (KEY_READ_SELECT) begin
			nxt_mode = fpl_pkg::FPL_KEYREAD;
		end else if (!SCAN_UPDATE_SELECT) begin
			nxt_mode = fpl_pkg::FPL_UPDATE;
		end else begin
			nxt_mode = fpl_pkg::FPL_SCAN;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mode_ff <= fpl_pkg::FPL_SCAN;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// edge detectors reset to the idle low level of their pins
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			step_d_ff <= 1'b0;
			gate_d_ff <= 1'b0;
		end else begin
			step_d_ff <= CPU_STEP_CLOCK;
			gate_d_ff <= GATE_ACTIVE;
		end
	end

	// scan clock divider and blanking interval
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			scan_cnt_ff <= 16'h0000;
			blank_cnt_ff <= 16'h0000;
		end else if (mode_ff != fpl_pkg::FPL_SCAN) begin
			scan_cnt_ff <= 16'h0000;
			blank_cnt_ff <= 16'h0000;
		end else if (scan_tick) begin
			scan_cnt_ff <= 16'h0000;
			blank_cnt_ff <= blank_ff;
		end else begin
			scan_cnt_ff <= scan_cnt_ff + 16'h0001;
			if (blanking) begin
				blank_cnt_ff <= blank_cnt_ff - 16'h0001;
			end
		end
	end

	// digit counter
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			digit_counter_ff <= 4'h0;
		end else if (mode_ff == fpl_pkg::FPL_SCAN) begin
			if (scan_tick) begin
				if (digit_counter_ff == fpl_pkg::LAST_DIGIT) begin
					digit_counter_ff <= 4'h0;
				end else begin
					digit_counter_ff <= digit_counter_ff + 4'h1;
				end
			end
		end else if (mode_ff == fpl_pkg::FPL_UPDATE && step_rise) begin
			if (CLEAR_LOAD_SELECT) begin
				digit_counter_ff <= 4'h0;
			end else begin
				digit_counter_ff <= digit_counter_ff + 4'h1;
			end
		end
	end

	// segment memory writes from processor write strobe in update mode or register bus
	always_ff @(posedge CLK) begin
		if (mode_ff == fpl_pkg::FPL_UPDATE && CPU_SEG_WRITE) begin
			seg_mem[digit_counter_ff] <= CPU_SEG_DATA;
		end else if (wb_wr && sel_seg) begin
			seg_mem[seg_idx] <= WB_DAT_I[7:0];
		end
	end

	// one-hot digit select and segment pattern, blanked
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DIGIT_DRIVE <= 16'h0000;
			SEGMENT_DRIVE <= 8'h00;
		end else if (mode_ff != fpl_pkg::FPL_SCAN || blanking) begin
			DIGIT_DRIVE <= 16'h0000;
			SEGMENT_DRIVE <= 8'h00;
		end else begin
			DIGIT_DRIVE <= digit_decoder;
			SEGMENT_DRIVE <= seg_mem[digit_counter_ff];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			GATE_LED <= 1'b0;
		end else begin
			GATE_LED <= GATE_ACTIVE;
		end
	end

	// row shifter
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			key_row_shifter_ff <= fpl_pkg::ROW_IDLE;
		end else if (!KEY_READ_SELECT) begin
			key_row_shifter_ff <= fpl_pkg::ROW_IDLE;
		end else if (step_rise) begin
			if (CLEAR_LOAD_SELECT) begin
				key_row_shifter_ff <= fpl_pkg::ROW_LOAD;
			end else begin
				key_row_shifter_ff <= {key_row_shifter_ff[2:0],
					key_row_shifter_ff[3]};
			end
		end
	end

	// key data buffer enabled in read mode; 4 rows, 7 columns
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			KEY_ROW <= fpl_pkg::ROW_IDLE;
			KEY_DATA <= 11'h000;
			KEY_DATA_EN <= 1'b0;
		end else begin
			KEY_ROW <= key_row_shifter_ff;
			KEY_DATA_EN <= KEY_READ_SELECT;
			if (KEY_READ_SELECT) begin
				KEY_DATA <= {key_row_shifter_ff, KEY_COLUMN_N};
			end else begin
				KEY_DATA <= 11'h000;
			end
		end
	end

	// stable count debounce, held until next read
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			deb_cnt_ff <= 16'h0000;
			key_hold_ff <= 1'b0;
		end else if (KEY_READ_SELECT) begin
			deb_cnt_ff <= 16'h0000;
			key_hold_ff <= 1'b0;
		end else begin
			if (!column_detector) begin
				deb_cnt_ff <= 16'h0000;
			end else if (!deb_done) begin
				deb_cnt_ff <= deb_cnt_ff + 16'h0001;
			end
			if (key_evt) begin
				key_hold_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			KEY_INT <= 1'b0;
		end else begin
			KEY_INT <= key_hold_ff | key_evt;
		end
	end

	// sticky status, set wins over write-one clear
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_st_ff <= fpl_pkg::IRQ_RST;
			IRQ <= 1'b0;
		end else begin
			irq_st_ff <= irq_next;
			IRQ <= |(irq_next & irq_mask_ff);
		end
	end

	// interrupt mask, same layout as status
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_mask_ff <= fpl_pkg::IRQ_RST;
		end else if (wb_wr && sel_imask) begin
			irq_mask_ff <= WB_DAT_I[1:0];
		end
	end

	// scan divider, ticks every setting plus one cycles
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			scan_div_ff <= fpl_pkg::SCAN_DIV_RST;
		end else if (full_wr && sel_div) begin
			scan_div_ff <= WB_DAT_I[15:0];
		end
	end

	// blank length sets the display brightness
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			blank_ff <= fpl_pkg::BLANK_RST;
		end else if (full_wr && sel_blank) begin
			blank_ff <= WB_DAT_I[15:0];
		end
	end

	// debounce length in clock cycles
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			debounce_ff <= fpl_pkg::DEBOUNCE_RST;
		end else if (full_wr && sel_deb) begin
			debounce_ff <= WB_DAT_I[15:0];
		end
	end

	// register read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_data = {29'h0, mode_ff};
		end else if (sel_stat) begin
			rd_data = {16'h0, key_row_shifter_ff, digit_counter_ff,
				6'h0, key_hold_ff, column_detector};
		end else if (sel_ist) begin
			rd_data = {30'h0, irq_st_ff};
		end else if (sel_imask) begin
			rd_data = {30'h0, irq_mask_ff};
		end else if (sel_div) begin
			rd_data = {16'h0, scan_div_ff};
		end else if (sel_blank) begin
			rd_data = {16'h0, blank_ff};
		end else if (sel_deb) begin
			rd_data = {16'h0, debounce_ff};
		end else if (sel_seg) begin
			rd_data = {24'h0, seg_mem[seg_idx]};
		end
	end

	// single-cycle ack, unmapped reads return zero
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= wb_req;
			WB_DAT_O <= wb_req ? rd_data : 32'h0000_0000;
		end
	end
endmodule : fpl_top

// >>> hw/fpl_pkg.sv
// constants for the front panel scan and keypad logic
// assumes a single 100 MHz clock and a classic wishbone register bus
package fpl_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam logic [3:0] NUM_DIGITS = 4'hF;
	localparam logic [3:0] LAST_DIGIT = 4'hE;
	localparam logic [3:0] ROW_LOAD = 4'h7;
	localparam logic [3:0] ROW_IDLE = 4'h0;
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_IRQ_ST = 8'h08;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] ADR_SCAN_DIV = 8'h10;
	localparam logic [7:0] ADR_BLANK = 8'h14;
	localparam logic [7:0] ADR_DEBOUNCE = 8'h18;
	localparam logic [7:0] ADR_SEG_BASE = 8'h40;
	localparam logic [15:0] SCAN_DIV_RST = 16'h0FA0;
	localparam logic [15:0] BLANK_RST = 16'h0100;
	localparam logic [15:0] DEBOUNCE_RST = 16'h0FFF;
	localparam logic [1:0] IRQ_RST = 2'h0;
	localparam int unsigned IRQ_KEY = 0;
	localparam int unsigned IRQ_GATE = 1;
	typedef enum logic [2:0] {
		FPL_SCAN = 3'b001,
		FPL_UPDATE = 3'b010,
		FPL_KEYREAD = 3'b100
	} fpl_mode_t;
endpackage : fpl_pkg

// >>> testbench/fpl_monitor.sv
// port assertions for the front panel scan and keypad block
// assumes one clock, CLK, and a synchronous active low RST_N
`timescale 1ns/10ps
module fpl_monitor (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic KEY_READ_SELECT,
	input wire logic SCAN_UPDATE_SELECT,
	input wire logic GATE_ACTIVE,
	input wire logic [6:0] KEY_COLUMN_N,
	input wire logic [15:0] DIGIT_DRIVE,
	input wire logic [7:0] SEGMENT_DRIVE,
	input wire logic GATE_LED,
	input wire logic [3:0] KEY_ROW,
	input wire logic [10:0] KEY_DATA,
	input wire logic KEY_DATA_EN,
	input wire logic KEY_INT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	seg_dark_a: assert property (
		DIGIT_DRIVE == 16'h0 |-> SEGMENT_DRIVE == 8'h0) else $error("seg lit");
	digit_onehot_a: assert property (
		$onehot0(DIGIT_DRIVE) && !DIGIT_DRIVE[15]) else $error("digit");
	update_dark_a: assert property (
		(!SCAN_UPDATE_SELECT && !KEY_READ_SELECT)[*2] |=>
		DIGIT_DRIVE == 16'h0) else $error("update lit");
	rows_low_a: assert property (
		(!KEY_READ_SELECT)[*2] |=> KEY_ROW == 4'h0) else $error("rows");
	buf_enable_a: assert property (
		KEY_READ_SELECT |=> KEY_DATA_EN) else $error("buf en");
	buf_off_a: assert property (
		!KEY_DATA_EN |-> KEY_DATA == 11'h0) else $error("buf data");
	gate_led_a: assert property (
		GATE_LED == $past(GATE_ACTIVE)) else $error("gate led");
	int_hold_a: assert property (
		KEY_INT && !KEY_READ_SELECT |=> KEY_INT) else $error("int drop");
	int_cause_a: assert property (
		$rose(KEY_INT) |-> $past(KEY_COLUMN_N) != 7'h7F) else $error("int");
	cover property ($rose(KEY_INT));
	cover property ($rose(GATE_LED));
	cover property (KEY_READ_SELECT && KEY_ROW == 4'h7);
endmodule : fpl_monitor

bind fpl_top fpl_monitor u_fpl_monitor (.CLK, .RST_N, .KEY_READ_SELECT,
	.SCAN_UPDATE_SELECT, .GATE_ACTIVE, .KEY_COLUMN_N, .DIGIT_DRIVE,
	.SEGMENT_DRIVE, .GATE_LED, .KEY_ROW, .KEY_DATA, .KEY_DATA_EN, .KEY_INT);

// >>> testbench/fpl_keypad_model.sv
// keypad matrix: a held key grounds its column while its row is low
// assumes rows come from the panel, columns have pull-ups
`timescale 1ns/10ps
module fpl_keypad_model (
	input wire logic press,
	input wire logic [1:0] row,
	input wire logic [2:0] col,
	input wire logic [3:0] key_row,
	output logic [6:0] col_n
);
	assign col_n = (press && !key_row[row]) ? ~(7'h01 << col) : 7'h7F;
endmodule : fpl_keypad_model

// >>> testbench/fpl_top_tb.sv
// self-checking bench for the front panel scan and keypad block
// assumes the keypad model on the columns and a wishbone master here
`timescale 1ns/10ps
module fpl_top_tb;
	typedef struct packed {
		logic we;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} fpl_row_t;
	logic CLK, RST_N, WB_WE_I, WB_CYC_I, WB_STB_I, KEY_READ_SELECT;
	logic CPU_STEP_CLOCK, SCAN_UPDATE_SELECT, CLEAR_LOAD_SELECT, press;
	logic CPU_SEG_WRITE, GATE_ACTIVE, WB_ACK_O, IRQ, GATE_LED;
	logic KEY_DATA_EN, KEY_INT;
	logic [7:0] WB_ADR_I, CPU_SEG_DATA, SEGMENT_DRIVE;
	logic [31:0] WB_DAT_I, WB_DAT_O, q;
	logic [3:0] WB_SEL_I, KEY_ROW, r;
	logic [6:0] KEY_COLUMN_N;
	logic [15:0] DIGIT_DRIVE, prev;
	logic [10:0] KEY_DATA;
	int bad_count = 0;
	int n_checks = 0;
	int i, j, k, z;
	fpl_row_t tbl [14];
	always #5 CLK = ~CLK;
	fpl_top u_fpl_top (.*);
	fpl_keypad_model u_fpl_keypad_model (.press(press), .row(2'h3),
		.col(3'h6), .key_row(KEY_ROW), .col_n(KEY_COLUMN_N));
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task hang_out;
		bad_count++;
		$display("ERROR %0t timeout", $time);
		give_verdict();
	endtask : hang_out
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		WB_WE_I <= w;
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (WB_ACK_O !== 1'b1 && n < 50);
		q = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		if (WB_ACK_O !== 1'b1) hang_out();
	endtask : wb
	task step(input logic c);
		@(posedge CLK);
		CLEAR_LOAD_SELECT <= c;
		CPU_STEP_CLOCK <= 1'b1;
		@(posedge CLK);
		CPU_STEP_CLOCK <= 1'b0;
		repeat (3) @(posedge CLK);
		#1;
	endtask : step
	task wait_int(input logic v);
		for (k = 0; k < 100 && KEY_INT !== v; k++) @(negedge CLK);
		if (KEY_INT !== v) hang_out();
	endtask : wait_int
	initial begin
		CLK = 1'b0;
		RST_N = 1'b0;
		{WB_WE_I, WB_CYC_I, WB_STB_I, KEY_READ_SELECT, press} = 5'h00;
		{CPU_STEP_CLOCK, CLEAR_LOAD_SELECT, CPU_SEG_WRITE, GATE_ACTIVE} = 4'h0;
		SCAN_UPDATE_SELECT = 1'b1;
		WB_SEL_I = 4'hF;
		WB_ADR_I = 8'h00;
		WB_DAT_I = 32'h0;
		CPU_SEG_DATA = 8'h00;
		tbl[0] = '{1'b0, fpl_pkg::ADR_CTRL, 32'h0, 32'h1};
		tbl[1] = '{1'b0, fpl_pkg::ADR_IRQ_ST, 32'h0, 32'h0};
		tbl[2] = '{1'b0, fpl_pkg::ADR_IRQ_MASK, 32'h0, 32'h0};
		tbl[3] = '{1'b0, fpl_pkg::ADR_SCAN_DIV, 32'h0, 32'h0FA0};
		tbl[4] = '{1'b0, fpl_pkg::ADR_BLANK, 32'h0, 32'h0100};
		tbl[5] = '{1'b0, fpl_pkg::ADR_DEBOUNCE, 32'h0, 32'h0FFF};
		tbl[6] = '{1'b1, 8'h30, 32'hFF, 32'h0};
		tbl[7] = '{1'b0, 8'h30, 32'h0, 32'h0};
		tbl[8] = '{1'b1, fpl_pkg::ADR_CTRL, 32'hFF, 32'h0};
		tbl[9] = '{1'b0, fpl_pkg::ADR_CTRL, 32'h0, 32'h1};
		tbl[10] = '{1'b1, fpl_pkg::ADR_SCAN_DIV, 32'h4, 32'h0};
		tbl[11] = '{1'b1, fpl_pkg::ADR_BLANK, 32'h1, 32'h0};
		tbl[12] = '{1'b1, fpl_pkg::ADR_DEBOUNCE, 32'h3, 32'h0};
		tbl[13] = '{1'b0, fpl_pkg::ADR_SCAN_DIV, 32'h0, 32'h4};
		repeat (5) @(posedge CLK);
		chk({IRQ, KEY_INT, GATE_LED, KEY_ROW}, 32'h0);
		RST_N <= 1'b1;
		for (i = 0; i < 14; i++) begin
			wb(tbl[i].we, tbl[i].a, tbl[i].d);
			if (!tbl[i].we) chk(q, tbl[i].e);
		end
		$display("register test done");
		@(posedge CLK);
		SCAN_UPDATE_SELECT <= 1'b0;
		step(1'b1);
		for (j = 0; j < 15; j++) begin
			@(posedge CLK);
			CPU_SEG_DATA <= 8'hA0 + 8'(j);
			CPU_SEG_WRITE <= 1'b1;
			@(posedge CLK);
			CPU_SEG_WRITE <= 1'b0;
			step(1'b0);
		end
		wb(1'b0, fpl_pkg::ADR_STAT, 32'h0);
		chk(q[11:8], 32'hF);
		wb(1'b0, fpl_pkg::ADR_CTRL, 32'h0);
		chk(q, 32'h2);
		step(1'b1);
		wb(1'b0, fpl_pkg::ADR_STAT, 32'h0);
		chk(q[11:8], 32'h0);
		@(posedge CLK);
		SCAN_UPDATE_SELECT <= 1'b1;
		prev = 16'h0;
		k = 0;
		z = 0;
		for (i = 0; i < 600 && k < 17; i++) begin
			@(negedge CLK);
			if (DIGIT_DRIVE == 16'h0) z++;
			if (DIGIT_DRIVE != 16'h0 && DIGIT_DRIVE !== prev) begin
				if (k > 0) chk(DIGIT_DRIVE, prev[14] ? 16'h1 : prev << 1);
				for (j = 0; j < 15; j++)
					if (DIGIT_DRIVE[j]) chk(SEGMENT_DRIVE, 8'hA0 + 8'(j));
				prev = DIGIT_DRIVE;
				k++;
			end
		end
		if (k < 17) hang_out();
		chk(z > 0, 1'b1);
		$display("display test done");
		wb(1'b1, fpl_pkg::ADR_IRQ_MASK, 32'h3);
		@(posedge CLK);
		press <= 1'b1;
		wait_int(1'b1);
		wb(1'b0, fpl_pkg::ADR_IRQ_ST, 32'h0);
		chk(q, 32'h1);
		chk(IRQ, 32'h1);
		@(posedge CLK);
		KEY_READ_SELECT <= 1'b1;
		wait_int(1'b0);
		step(1'b1);
		chk(KEY_ROW, 4'h7);
		r = 4'h7;
		for (i = 0; i < 4; i++) begin
			step(1'b0);
			r = {r[2:0], r[3]};
			chk(KEY_ROW, r);
			chk(KEY_DATA, {r, r[3] ? 7'h7F : 7'h3F});
		end
		@(posedge CLK);
		KEY_READ_SELECT <= 1'b0;
		press <= 1'b0;
		wb(1'b1, fpl_pkg::ADR_IRQ_ST, 32'h1);
		wb(1'b1, fpl_pkg::ADR_IRQ_MASK, 32'h1);
		@(posedge CLK);
		GATE_ACTIVE <= 1'b1;
		repeat (3) @(posedge CLK);
		GATE_ACTIVE <= 1'b0;
		wb(1'b0, fpl_pkg::ADR_IRQ_ST, 32'h0);
		chk(q, 32'h2);
		chk(IRQ, 32'h0);
		wb(1'b1, fpl_pkg::ADR_IRQ_ST, 32'h2);
		wb(1'b0, fpl_pkg::ADR_IRQ_ST, 32'h0);
		chk(q, 32'h0);
		$display("keypad and gate test done");
		give_verdict();
	end
endmodule : fpl_top_tb
